// >>> core/icofx_params.svh
`ifndef ICOFX_PARAMS_SVH
`define ICOFX_PARAMS_SVH
// ---------------------------------------------------------------
// register indices
// ---------------------------------------------------------------
`define ICOFX_IDX_ICON2 8'h2c
`define ICOFX_IDX_ICON3 8'h2d
`define ICOFX_IDX_OVL 8'h2e
`define ICOFX_IDX_HFA 8'h2f
`define ICOFX_IDX_OFS0 8'h09
`define ICOFX_RST_VAL 8'h00
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ICOFX_B_PCI_EN 7
`define ICOFX_B_PCI_SWAP 6
`define ICOFX_B_REF_HI 7
`define ICOFX_B_REF_LO 6
`define ICOFX_B_MAP 5
`define ICOFX_B_VDBL 4
`define ICOFX_B_HDBL 3
`define ICOFX_B_BLINK 2
`define ICOFX_B_MODE 1
`define ICOFX_B_EN 0
`define ICOFX_B_EARLY_HI 7
`define ICOFX_B_EARLY_LO 5
`define ICOFX_B_WDLY_HI 4
`define ICOFX_B_WDLY_LO 3
`define ICOFX_B_MAP0_HI 2
`define ICOFX_B_MAP0_LO 1
`define ICOFX_B_FINE 0
`define ICOFX_HFA_MASK 8'h0f
`define ICOFX_ICON_CLEAR 2'h0
// ---------------------------------------------------------------
// counts
// ---------------------------------------------------------------
`define ICOFX_HFA_DEPTH 5'h10
`define ICOFX_LEAD_MAX 4'h8
`define ICOFX_LINE_LEN 8
`endif

// >>> core/icofx_pkg.sv
`default_nettype none
package icofx_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic gr_sel;
        logic [7:0] index;
        logic [7:0] wdata;
    } icofx_host_req_type;

    typedef struct packed {
        logic [7:0] line;
    } icofx_line_state_type;

    typedef struct packed {
        logic [8:0] mem_addr;
    } icofx_ofs_state_type;

    typedef struct packed {
        logic [1:0][7:0] icon;
        logic [7:0] ovl;
        logic [3:0] hfa_thr;
        logic [7:0] ofs0;
        logic [7:0] rdata;
        logic [1:0] pins_s1;
        logic [1:0] pins_s2;
        logic [4:0] hfa_lvl;
        logic refill;
        logic blink_prev;
        logic blink_phase;
        logic win_hit;
        logic [31:0] pci_data;
        logic lb_claim;
        logic lin_mode;
        logic base_map;
        logic [1:0] opaque;
        logic [1:0][5:0] pix_row;
        logic [1:0][5:0] pix_col;
        logic [1:0] map;
        logic [2:0] icon0_map;
        logic [3:0] fine;
        logic win;
    } icofx_state_type;
endpackage
`default_nettype wire

// >>> core/icofx_tap_line.sv
`timescale 1ns/10ps
`default_nettype none
`include "icofx_params.svh"
module icofx_tap_line
    import icofx_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic d_i,
    input wire logic [3:0] tap_i,
    output logic q_o
);
    icofx_line_state_type st_q;
    icofx_line_state_type st_d;
    logic [`ICOFX_LINE_LEN:0] taps;

    // ---------------------------------------------------------------
    // shift line, tap 0 is the input itself
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.line = {st_q.line[`ICOFX_LINE_LEN-2:0], d_i};
        taps = {st_q.line, d_i};
        q_o = (tap_i > `ICOFX_LEAD_MAX) ? 1'b0 : taps[tap_i];
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // icofx_tap_line
`default_nettype wire

// >>> core/icofx_offset_add.sv
`timescale 1ns/10ps
`default_nettype none
`include "icofx_params.svh"
module icofx_offset_add
    import icofx_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [8:0] adjusted_bus_address_i,
    input wire logic [7:0] offset_i,
    input wire logic granularity_i,
    output logic [8:0] display_memory_address_o
);
    icofx_ofs_state_type st_q;
    icofx_ofs_state_type st_d;

    // ---------------------------------------------------------------
    // 4k: bits 19:12 plus offset, 16k: bits 20:14 plus offset 6:0
    // ---------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (granularity_i) begin
            st_d.mem_addr = {adjusted_bus_address_i[8:2] + offset_i[6:0],
                adjusted_bus_address_i[1:0]};
        end else begin
            st_d.mem_addr = {1'b0, adjusted_bus_address_i[7:0] + offset_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign display_memory_address_o = st_q.mem_addr;

    a_ofs_fine: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !granularity_i |=> display_memory_address_o[7:0]
            == $past(adjusted_bus_address_i[7:0] + offset_i))
        else $error("offset sum at 4k granularity wrong");
endmodule // icofx_offset_add
`default_nettype wire

// >>> core/icofx_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "icofx_params.svh"
module icofx_regs
    import icofx_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire icofx_host_req_type host_req_i,
    output logic [7:0] host_rdata_o,
    input wire logic pci_mode_i,
    input wire logic [7:0] pci_addr_hi_i,
    input wire logic [7:0] pci_base1_hi_i,
    input wire logic [31:0] pci_wdata_i,
    output logic pci_win_hit_o,
    output logic [31:0] pci_data_o,
    input wire logic [1:0] upper_addr_pins_i,
    input wire logic [23:12] bus_addr_i,
    input wire logic [3:0] segment_select_field_i,
    output logic lb_claim_o,
    output logic linear_mode_o,
    output logic base_map_o,
    input wire logic granularity_i,
    output logic [8:0] display_memory_address_o,
    input wire logic [6:0] scan_row_i,
    input wire logic [6:0] scan_col_i,
    input wire logic [1:0][1:0] icon_pixel_i,
    input wire logic cursor_blink_i,
    output logic [1:0] icon_opaque_o,
    output logic [1:0][5:0] icon_pix_row_o,
    output logic [1:0][5:0] icon_pix_col_o,
    output logic [1:0] icon_map_o,
    input wire logic icon0_map_sel_i,
    input wire logic icon1_map_sel_i,
    output logic [2:0] icon0_map_o,
    input wire logic cursor_lock_i,
    input wire logic expanded_i,
    input wire logic [2:0] fine_lo_i,
    output logic [3:0] cursor_fine_o,
    input wire logic double_rate_i,
    input wire logic ovl_window_adv_i,
    output logic overlay_window_out_n_o,
    input wire logic mem_wr_req_i,
    output logic mem_wr_start_o,
    input wire logic dual_scan_i,
    input wire logic hfa_fill_i,
    input wire logic hfa_pop_i,
    output logic hfa_refill_req_o,
    output logic [4:0] hfa_level_o
);
    icofx_state_type st_q;
    icofx_state_type st_d;
    logic [3:0] lead_tap;
    logic [3:0] wdly_tap;
    logic win_tap;
    logic [4:0] hfa_empty;
    logic fill_ok;
    logic pop_ok;
    logic single_icon;

    // ---------------------------------------------------------------
    // lookups
    // ---------------------------------------------------------------
    function automatic logic [3:0] lead_of(input logic [2:0] code, input logic dbl);
        logic [3:0] n;
        n = 4'h0;
        if (dbl) begin
            unique case (code)
                3'h0: n = 4'h3;
                3'h1: n = 4'h4;
                3'h2: n = 4'h5;
                3'h3: n = 4'h6;
                3'h4: n = 4'h7;
                3'h5: n = 4'h8;
                3'h6: n = 4'h2;
                3'h7: n = 4'h1;
            endcase
        end else begin
            unique case (code)
                3'h4: n = 4'h1;
                3'h5: n = 4'h2;
                default: n = 4'h0;
            endcase
        end
        return n;
    endfunction

    function automatic logic [5:0] icon_coord(input logic [6:0] c, input logic dbl);
        return dbl ? c[6:1] : c[5:0];
    endfunction

    function automatic logic [31:0] swap_bytes(input logic [31:0] w);
        return {w[23:16], w[31:24], w[7:0], w[15:8]};
    endfunction

    // ---------------------------------------------------------------
    // timing lines
    // ---------------------------------------------------------------
    // window input leads the real window by max lead plus one
    assign lead_tap = `ICOFX_LEAD_MAX - lead_of(
        st_q.ovl[`ICOFX_B_EARLY_HI:`ICOFX_B_EARLY_LO], double_rate_i);
    assign wdly_tap = (st_q.ovl[`ICOFX_B_WDLY_HI:`ICOFX_B_WDLY_LO] == 2'h3) ? 4'h0
        : {2'h0, 2'h2 - st_q.ovl[`ICOFX_B_WDLY_HI:`ICOFX_B_WDLY_LO]};

    icofx_tap_line u_win_line (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(ovl_window_adv_i),
        .tap_i(lead_tap),
        .q_o(win_tap)
    );

    icofx_tap_line u_wr_line (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(mem_wr_req_i),
        .tap_i(wdly_tap),
        .q_o(mem_wr_start_o)
    );

    icofx_offset_add u_ofs (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .adjusted_bus_address_i(bus_addr_i[20:12]),
        .offset_i(st_q.ofs0),
        .granularity_i(granularity_i),
        .display_memory_address_o(display_memory_address_o)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    assign hfa_empty = `ICOFX_HFA_DEPTH - st_q.hfa_lvl;
    assign fill_ok = hfa_fill_i && (st_q.hfa_lvl != `ICOFX_HFA_DEPTH);
    assign pop_ok = hfa_pop_i && (st_q.hfa_lvl != 5'h0);
    assign single_icon = st_q.ovl[`ICOFX_B_MAP0_HI:`ICOFX_B_MAP0_LO] != `ICOFX_ICON_CLEAR;

    always_comb begin
        st_d = st_q;
        // host writes
        if (host_req_i.wr && host_req_i.gr_sel) begin
            if (host_req_i.index == `ICOFX_IDX_OFS0) begin
                st_d.ofs0 = host_req_i.wdata;
            end
        end else if (host_req_i.wr) begin
            unique case (host_req_i.index)
                `ICOFX_IDX_ICON2: st_d.icon[0] = host_req_i.wdata;
                `ICOFX_IDX_ICON3: st_d.icon[1] = host_req_i.wdata;
                `ICOFX_IDX_OVL: begin
                    st_d.ovl[7:1] = host_req_i.wdata[7:1];
                    if (!cursor_lock_i) begin
                        st_d.ovl[`ICOFX_B_FINE] = host_req_i.wdata[`ICOFX_B_FINE];
                    end
                end
                `ICOFX_IDX_HFA: st_d.hfa_thr = host_req_i.wdata[3:0];
                default: ;
            endcase
        end
        // host reads
        st_d.rdata = `ICOFX_RST_VAL;
        if (host_req_i.rd && host_req_i.gr_sel) begin
            if (host_req_i.index == `ICOFX_IDX_OFS0) begin
                st_d.rdata = st_q.ofs0;
            end
        end else if (host_req_i.rd) begin
            unique case (host_req_i.index)
                `ICOFX_IDX_ICON2: st_d.rdata = st_q.icon[0];
                `ICOFX_IDX_ICON3: st_d.rdata = st_q.icon[1];
                `ICOFX_IDX_OVL: st_d.rdata = {st_q.ovl[7:1],
                    st_q.ovl[`ICOFX_B_FINE] & expanded_i};
                `ICOFX_IDX_HFA: st_d.rdata = {4'h0, st_q.hfa_thr} & `ICOFX_HFA_MASK;
                default: ;
            endcase
        end
        // pci window
        st_d.win_hit = pci_mode_i && st_q.icon[0][`ICOFX_B_PCI_EN]
            && (pci_addr_hi_i == pci_base1_hi_i);
        st_d.pci_data = (st_d.win_hit && st_q.icon[0][`ICOFX_B_PCI_SWAP])
            ? swap_bytes(pci_wdata_i) : pci_wdata_i;
        // upper address decode
        st_d.pins_s1 = upper_addr_pins_i;
        st_d.pins_s2 = st_q.pins_s1;
        st_d.lb_claim = !pci_mode_i
            && (st_q.pins_s2 == st_q.icon[1][`ICOFX_B_REF_HI:`ICOFX_B_REF_LO])
            && (bus_addr_i[23:20] == segment_select_field_i);
        st_d.lin_mode = pci_mode_i
            && (st_q.icon[1][`ICOFX_B_REF_HI:`ICOFX_B_REF_LO] != 2'h0);
        st_d.base_map = pci_mode_i
            && ((st_q.icon[1][`ICOFX_B_REF_HI:`ICOFX_B_REF_LO] != 2'h0)
            || (segment_select_field_i != 4'h0));
        // icons 2 and 3
        st_d.blink_prev = cursor_blink_i;
        if (cursor_blink_i && !st_q.blink_prev) begin
            st_d.blink_phase = !st_q.blink_phase;
        end
        for (int i = 0; i < 2; i++) begin
            st_d.pix_row[i] = icon_coord(scan_row_i, st_q.icon[i][`ICOFX_B_VDBL]);
            st_d.pix_col[i] = icon_coord(scan_col_i, st_q.icon[i][`ICOFX_B_HDBL]);
            st_d.map[i] = st_q.icon[i][`ICOFX_B_MAP];
            st_d.opaque[i] = st_q.icon[i][`ICOFX_B_EN] && !single_icon
                && (!st_q.icon[i][`ICOFX_B_BLINK] || st_q.blink_phase)
                && (st_q.icon[i][`ICOFX_B_VDBL] || !scan_row_i[6])
                && (st_q.icon[i][`ICOFX_B_HDBL] || !scan_col_i[6])
                && !(st_q.icon[i][`ICOFX_B_MODE] && icon_pixel_i[i] == 2'h0);
        end
        st_d.icon0_map = single_icon
            ? {st_q.ovl[`ICOFX_B_MAP0_HI:`ICOFX_B_MAP0_LO], icon1_map_sel_i}
            : {2'h0, icon0_map_sel_i};
        // cursor fine position
        st_d.fine = {st_q.ovl[`ICOFX_B_FINE] & expanded_i, fine_lo_i};
        // overlay window
        st_d.win = win_tap;
        // half-frame fifo level and refill
        st_d.hfa_lvl = st_q.hfa_lvl + {4'h0, fill_ok} - {4'h0, pop_ok};
        st_d.refill = dual_scan_i && (hfa_empty != 5'h0)
            && (hfa_empty >= {1'b0, st_q.hfa_thr});
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign host_rdata_o = st_q.rdata;
    assign pci_win_hit_o = st_q.win_hit;
    assign pci_data_o = st_q.pci_data;
    assign lb_claim_o = st_q.lb_claim;
    assign linear_mode_o = st_q.lin_mode;
    assign base_map_o = st_q.base_map;
    assign icon_opaque_o = st_q.opaque;
    assign icon_pix_row_o = st_q.pix_row;
    assign icon_pix_col_o = st_q.pix_col;
    assign icon_map_o = st_q.map;
    assign icon0_map_o = st_q.icon0_map;
    assign cursor_fine_o = st_q.fine;
    assign overlay_window_out_n_o = !st_q.win;
    assign hfa_refill_req_o = st_q.refill;
    assign hfa_level_o = st_q.hfa_lvl;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_lead3_cfg;
        double_rate_i && st_q.ovl[`ICOFX_B_EARLY_HI:`ICOFX_B_EARLY_LO] == 3'h0;
    endsequence

    sequence s_window_rise;
        $rose(ovl_window_adv_i) ##0 s_lead3_cfg;
    endsequence

    a_pci_win_hit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (pci_mode_i && st_q.icon[0][`ICOFX_B_PCI_EN] && pci_addr_hi_i == pci_base1_hi_i)
            |=> pci_win_hit_o)
        else $error("enabled pci window not decoded");
    a_pci_win_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !st_q.icon[0][`ICOFX_B_PCI_EN] |=> !pci_win_hit_o)
        else $error("disabled pci window decoded");
    a_byte_swap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (pci_mode_i && st_q.icon[0][`ICOFX_B_PCI_EN] && st_q.icon[0][`ICOFX_B_PCI_SWAP]
            && pci_addr_hi_i == pci_base1_hi_i)
            |=> pci_data_o == {$past(pci_wdata_i[23:16]), $past(pci_wdata_i[31:24]),
                $past(pci_wdata_i[7:0]), $past(pci_wdata_i[15:8])})
        else $error("byte swap order wrong");
    a_lb_claim: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lb_claim_o |-> $past(!pci_mode_i && bus_addr_i[23:20] == segment_select_field_i))
        else $error("local claim without segment match");
    a_icon0_map: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        single_icon && $stable(st_q.ovl) |=> icon0_map_o
            == {$past(st_q.ovl[`ICOFX_B_MAP0_HI:`ICOFX_B_MAP0_LO]), $past(icon1_map_sel_i)})
        else $error("icon 0 map index wrong");
    a_icon_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !st_q.icon[0][`ICOFX_B_EN] |=> !icon_opaque_o[0])
        else $error("disabled icon drawn");
    a_lead_three: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_window_rise ##1 s_lead3_cfg [*5] |=> $fell(overlay_window_out_n_o))
        else $error("overlay window lead not three clocks");
    a_write_delay: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (mem_wr_req_i && st_q.ovl[`ICOFX_B_WDLY_HI:`ICOFX_B_WDLY_LO] == 2'h0
            ##1 st_q.ovl[`ICOFX_B_WDLY_HI:`ICOFX_B_WDLY_LO] == 2'h0 [*2])
            |-> mem_wr_start_o)
        else $error("write start not two clocks late");
    a_fine_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !expanded_i |=> !cursor_fine_o[3])
        else $error("fine msb not zero unexpanded");
    a_cursor_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cursor_lock_i |=> $stable(st_q.ovl[`ICOFX_B_FINE]))
        else $error("cursor position changed while locked");
    a_fifo_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        hfa_level_o <= `ICOFX_HFA_DEPTH)
        else $error("fifo level beyond sixteen");
    a_refill_dual: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        hfa_refill_req_o |-> $past(dual_scan_i && hfa_empty >= {1'b0, st_q.hfa_thr}))
        else $error("refill request without threshold");
endmodule // icofx_regs
`default_nettype wire

// >>> tb/icofx_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module icofx_host_model
    import icofx_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] host_rdata_i,
    output var icofx_host_req_type host_req_o
);
    // ----------------
    // indexed cycles, launched at the falling edge
    // ----------------
    initial host_req_o = '0;
    task automatic wr(input logic gr, input logic [7:0] idx, input logic [7:0] d);
        @(negedge clk_i);
        host_req_o = {1'b1, 1'b0, gr, idx, d};
        @(negedge clk_i);
        host_req_o = '0;
    endtask
    task automatic rd(input logic gr, input logic [7:0] idx, output logic [7:0] q);
        @(negedge clk_i);
        host_req_o = {1'b0, 1'b1, gr, idx, 8'h00};
        @(negedge clk_i);
        host_req_o = '0;
        q = host_rdata_i;
    endtask
endmodule // icofx_host_model
`default_nettype wire

// >>> tb/icon_overlay_fifo_ext_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module icon_overlay_fifo_ext_regs_bench
    import icofx_pkg::*;
;
    // ----------------
    // signals
    // ----------------
    typedef struct packed {logic gr; logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} icofx_row_type;
    icofx_row_type rows [7] = '{'{1'b0, 8'h2c, 8'ha5, 8'ha5}, '{1'b0, 8'h2d, 8'h5a, 8'h5a},
        '{1'b0, 8'h2f, 8'hff, 8'h0f}, '{1'b1, 8'h09, 8'h3c, 8'h3c}, '{1'b0, 8'h30, 8'hff, 8'h00},
        '{1'b1, 8'h2c, 8'h77, 8'h00}, '{1'b0, 8'h2e, 8'he6, 8'he6}};
    logic [7:0] ridx [5] = '{8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h09};
    logic [2:0] code [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 0, 3, 4, 5};
    int lead [12] = '{3, 4, 5, 6, 7, 8, 2, 1, 0, 0, 1, 2};
    int bad_count = 0, n_compared = 0, cyc = 0, n;
    logic clk_i = 1'b0, rst = 1'b1, pmode = 1'b0, gran = 1'b0, blink = 1'b0, m0 = 1'b0;
    logic m1 = 1'b0, lock = 1'b0, exp_m = 1'b1, dr = 1'b0, adv = 1'b0, wreq = 1'b0;
    logic dual = 1'b0, fill = 1'b0, pop = 1'b0;
    logic [7:0] pahi = 8'h00, pbase = 8'h12, q;
    logic [31:0] pwd = 32'h11223344;
    logic [1:0] pins = 2'b00;
    logic [23:12] baddr = 12'h000;
    logic [3:0] seg = 4'h0;
    logic [6:0] row = 7'h00, col = 7'h00;
    logic [1:0][1:0] pix = 4'h0;
    logic [2:0] flo = 3'h0, s;
    icofx_host_req_type req;
    logic [7:0] rdata;
    logic [31:0] pdata;
    logic phit, claim, lin, bmap, ovn, wst, refill;
    logic [8:0] maddr;
    logic [1:0] opq, imap;
    logic [1:0][5:0] prow, pcol;
    logic [2:0] i0map;
    logic [3:0] fine;
    logic [4:0] lvl;
    icofx_host_model host (.clk_i(clk_i), .host_rdata_i(rdata), .host_req_o(req));
    icofx_regs dut (.clk_i(clk_i), .sys_rst_i(rst), .host_req_i(req), .host_rdata_o(rdata),
        .pci_mode_i(pmode), .pci_addr_hi_i(pahi), .pci_base1_hi_i(pbase), .pci_wdata_i(pwd),
        .pci_win_hit_o(phit), .pci_data_o(pdata), .upper_addr_pins_i(pins), .bus_addr_i(baddr),
        .segment_select_field_i(seg), .lb_claim_o(claim), .linear_mode_o(lin),
        .base_map_o(bmap), .granularity_i(gran), .display_memory_address_o(maddr),
        .scan_row_i(row), .scan_col_i(col), .icon_pixel_i(pix), .cursor_blink_i(blink),
        .icon_opaque_o(opq), .icon_pix_row_o(prow), .icon_pix_col_o(pcol), .icon_map_o(imap),
        .icon0_map_sel_i(m0), .icon1_map_sel_i(m1), .icon0_map_o(i0map),
        .cursor_lock_i(lock), .expanded_i(exp_m), .fine_lo_i(flo), .cursor_fine_o(fine),
        .double_rate_i(dr), .ovl_window_adv_i(adv), .overlay_window_out_n_o(ovn),
        .mem_wr_req_i(wreq), .mem_wr_start_o(wst), .dual_scan_i(dual), .hfa_fill_i(fill),
        .hfa_pop_i(pop), .hfa_refill_req_o(refill), .hfa_level_o(lvl));
    // ----------------
    // helpers
    // ----------------
    initial forever #2.5 clk_i = ~clk_i;
    task automatic step(input int k);
        repeat (k) @(negedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] ex);
        n_compared++;
        if (got !== ex) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict;
        end
    end
    // ----------------
    // sequence
    // ----------------
    initial begin
        step(16);
        rst = 1'b0;
        chk(ovn, 1'b1);
        for (int i = 0; i < 5; i++) begin
            host.rd(i == 4, ridx[i], q);
            chk(q, 8'h00);
        end
        foreach (rows[i]) begin
            host.wr(rows[i].gr, rows[i].idx, rows[i].wd);
            host.rd(rows[i].gr, rows[i].idx, q);
            chk(q, rows[i].ex);
        end
        rst = 1'b1;
        step(3);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            host.rd(i == 4, ridx[i], q);
            chk(q, 8'h00);
        end
        host.wr(1'b0, 8'h2c, 8'hc0);
        pmode = 1'b1;
        pahi = 8'h12;
        step(2);
        chk(phit, 1'b1);
        chk(pdata, 32'h22114433);
        pahi = 8'h13;
        step(2);
        chk(phit, 1'b0);
        host.wr(1'b0, 8'h2d, 8'h40);
        pmode = 1'b0;
        pins = 2'b01;
        seg = 4'h5;
        baddr = 12'h500;
        step(4);
        chk(claim, 1'b1);
        pins = 2'b10;
        step(4);
        chk(claim, 1'b0);
        pmode = 1'b1;
        step(2);
        chk(lin, 1'b1);
        chk(bmap, 1'b1);
        host.wr(1'b0, 8'h2d, 8'h00);
        seg = 4'h0;
        step(2);
        chk(lin, 1'b0);
        chk(bmap, 1'b0);
        pmode = 1'b0;
        host.wr(1'b1, 8'h09, 8'hf0);
        baddr = 12'h020;
        step(2);
        chk(maddr, 9'h010);
        gran = 1'b1;
        baddr = 12'h017;
        step(2);
        chk(maddr, 9'h1d7);
        host.wr(1'b0, 8'h2e, 8'h00);
        host.wr(1'b0, 8'h2c, 8'h23);
        pix = 4'h1;
        step(2);
        chk(opq[0], 1'b1);
        chk(imap[0], 1'b1);
        pix = 4'h0;
        step(2);
        chk(opq[0], 1'b0);
        pix = 4'h1;
        row = 7'h40;
        step(2);
        chk(opq[0], 1'b0);
        row = 7'h00;
        host.wr(1'b0, 8'h2c, 8'h22);
        step(2);
        chk(opq[0], 1'b0);
        host.wr(1'b0, 8'h2c, 8'h23);
        host.wr(1'b0, 8'h2e, 8'h04);
        m1 = 1'b1;
        step(2);
        chk(i0map, 3'h5);
        chk(opq[0], 1'b0);
        host.wr(1'b0, 8'h2e, 8'h01);
        flo = 3'h5;
        step(2);
        chk(fine, 4'hd);
        lock = 1'b1;
        host.wr(1'b0, 8'h2e, 8'h00);
        host.rd(1'b0, 8'h2e, q);
        chk(q, 8'h01);
        exp_m = 1'b0;
        step(2);
        chk(fine, 4'h5);
        lock = 1'b0;
        host.wr(1'b0, 8'h2c, 8'h1d);
        row = 7'h45;
        col = 7'h7e;
        step(2);
        chk(prow[0], 6'h22);
        chk(pcol[0], 6'h3f);
        chk(prow[1], 6'h05);
        chk(pcol[1], 6'h3e);
        chk(opq[0], 1'b0);
        blink = 1'b1;
        step(2);
        chk(opq[0], 1'b1);
        blink = 1'b0;
        step(2);
        blink = 1'b1;
        step(2);
        chk(opq[0], 1'b0);
        blink = 1'b0;
        row = 7'h00;
        col = 7'h00;
        for (int i = 0; i < 4; i++) begin
            host.wr(1'b0, 8'h2e, 8'(i << 3));
            step(10);
            wreq = 1'b1;
            #1 s[0] = wst;
            @(negedge clk_i);
            wreq = 1'b0;
            #1 s[1] = wst;
            @(negedge clk_i);
            #1 s[2] = wst;
            chk(s, (i == 3) ? 3'h1 : 3'(4 >> i));
        end
        for (int i = 0; i < 12; i++) begin
            dr = i < 8;
            host.wr(1'b0, 8'h2e, {code[i], 5'h00});
            @(negedge clk_i);
            adv = 1'b1;
            n = 0;
            while (ovn === 1'b1 && n < 20) begin
                @(negedge clk_i);
                n++;
            end
            chk(n, 9 - lead[i]);
            adv = 1'b0;
            step(14);
        end
        host.wr(1'b0, 8'h2f, 8'h04);
        dual = 1'b1;
        fill = 1'b1;
        step(17);
        fill = 1'b0;
        step(2);
        chk(lvl, 5'h10);
        chk(refill, 1'b0);
        pop = 1'b1;
        step(3);
        pop = 1'b0;
        step(2);
        chk(refill, 1'b0);
        pop = 1'b1;
        step(1);
        pop = 1'b0;
        step(2);
        chk(refill, 1'b1);
        dual = 1'b0;
        step(2);
        chk(refill, 1'b0);
        pop = 1'b1;
        step(13);
        pop = 1'b0;
        step(2);
        chk(lvl, 5'h00);
        print_verdict;
    end
endmodule // icon_overlay_fifo_ext_regs_bench
`default_nettype wire
